// file: rtl/adcsp_consts.svh
/*
  Constants of the converter serial command port: command codes, register
  map limits, reset values, status layout and timeout counts.
  Assumes inclusion by rtl/adcsp_top.sv and by the bench.
*/
`ifndef ADCSP_CONSTS_SVH
`define ADCSP_CONSTS_SVH
`define ADCSP_CMD_RDDATA 3'h1
`define ADCSP_CMD_WRITE 3'h3
`define ADCSP_CMD_RESET 3'h6
`define ADCSP_LAST_ADDR 4'h9
`define ADCSP_ID_ADDR 4'h9
`define ADCSP_NREG 10
`define ADCSP_RST_CONV_CTL0 8'h0A
`define ADCSP_RST_CONV_CTL1 8'h83
`define ADCSP_RST_FIXED_SEL 8'h00
`define ADCSP_RST_PAIR_SCAN 8'h00
`define ADCSP_RST_SINGLE_SCAN_LO 8'hFF
`define ADCSP_RST_SINGLE_SCAN_HI 8'hFF
`define ADCSP_RST_MON_SCAN 8'h00
`define ADCSP_RST_PORT_DIR 8'hFF
`define ADCSP_RST_PORT_DATA 8'h00
`define ADCSP_STAT_BIT 1
`define ADCSP_TOSEL_BIT 6
`define ADCSP_TO_LONG_CYC 13'h1000
`define ADCSP_TO_SHORT_CYC 13'h0100
`define ADCSP_LEN_STAT 6'h20
`define ADCSP_LEN_NOSTAT 6'h18
`define ADCSP_POS_FS 24'h7FFFFF
`define ADCSP_NEG_FS 24'h800000
`define ADCSP_TAG_LAST_EXT 5'h17
`define ADCSP_TAG_OFFSET 5'h18
`define ADCSP_TAG_SUPPLY 5'h1A
`define ADCSP_TAG_REF 5'h1D
`endif

// file: rtl/adcsp_pkg.sv
/*
  Types of the converter serial command port.
  Assumes nothing of its surroundings.
*/
package adcsp_pkg;
  typedef enum logic [1:0] {st_cmd, st_write, st_read} adcsp_state_t;
  typedef struct packed {
    logic [23:0] data;
    logic overrange_flag;
    logic [4:0] tag;
  } adcsp_result_t;
endpackage

// file: rtl/adcsp_top.sv
/*
  Serial command port of a multi-channel converter with its result FIFO.
  Assumes a host that drives cs_n, sclk and din asynchronously to mclk,
  and conversion logic on mclk that offers results with valid and ready.
*/
// Overview of operation
// - Command code 011 starts a register write
// - Multi-access bit set writes successive registers
// - Low four command bits give start address
// - Eight rising edges after command form data
// - Multi-write increments address, ends after 09h
// - Reset command restores all configuration defaults
// - Result after reset command marked invalid
// - Readout is four or three bytes by stat
// - Status byte first, then data MSB first
// - Fresh flag set on update, cleared by read
// - Unread result is overwritten by newer one
// - Overrange sets flag and saturates the code
// - Status bit 5 mirrors low supply monitor
// - Status bits 4..0 carry channel tag
// - Result is 24-bit two's complement
// - Tags 00h-17h name external inputs
// - Tags 18h and 1Ah-1Dh name internal monitor readings
// - Command byte: code, multi bit, address
// - Code 110 is reset, rest ignored
// - Chip select high aborts, returns to idle
`timescale 1ns/1ps
`include "adcsp_consts.svh"

////////////////////////////////////////////////////////////////////////
// Result FIFO
module adcsp_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two");
    end
  endgenerate
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr, rptr, next_wptr, next_rptr;
  logic push, pop;

  // Full and empty from pointers with a wrap bit
  always_comb begin
    in_ready = (wptr ^ rptr) != {1'b1, {AW{1'b0}}};
    out_valid = wptr != rptr;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wptr = wptr + (AW+1)'(push);
    next_rptr = rptr + (AW+1)'(pop);
    out_data = mem[rptr[AW-1:0]];
  end

  // Pointer and storage update
  always_ff @(posedge mclk) begin
    if (srst) begin
      wptr <= '0;
      rptr <= '0;
    end else if (ce) begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      if (push) begin
        mem[wptr[AW-1:0]] <= in_data;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// Serial command port
module adcsp_top #(
  parameter logic [7:0] ID_VALUE = 8'h5A, // Arbitrary identification value
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire adcsp_pkg::adcsp_result_t conv_result,
  input wire logic supply_low,
  output logic result_ready_n,
  output logic result_invalid,
  output logic [`ADCSP_NREG-1:0][7:0] cfg_regs,
  output logic reset_cmd
);
  localparam logic [`ADCSP_NREG-1:0][7:0] CFG_DEF = {ID_VALUE, `ADCSP_RST_PORT_DATA,
    `ADCSP_RST_PORT_DIR, `ADCSP_RST_MON_SCAN, `ADCSP_RST_SINGLE_SCAN_HI, `ADCSP_RST_SINGLE_SCAN_LO,
    `ADCSP_RST_PAIR_SCAN, `ADCSP_RST_FIXED_SEL, `ADCSP_RST_CONV_CTL1, `ADCSP_RST_CONV_CTL0};

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [2:0] s1, s2, s3, pin, next_pin;
  logic cs_c, sclk_rise, sclk_fall, din_c;
  always_comb begin
    next_pin = pin;
    for (int i = 0; i < 3; i++) begin
      if (s2[i] == s3[i]) begin
        next_pin[i] = s3[i];
      end
    end
    cs_c = pin[2];
    din_c = pin[0];
    sclk_rise = !pin[1] && next_pin[1];
    sclk_fall = pin[1] && !next_pin[1];
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1 <= 3'h4;
      s2 <= 3'h4;
      s3 <= 3'h4;
      pin <= 3'h4;
    end else if (ce) begin
      s1 <= {cs_n, sclk, din};
      s2 <= s1;
      s3 <= s2;
      pin <= next_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial command state
  adcsp_pkg::adcsp_state_t state, next_state;
  logic [2:0] bits, next_bits;
  logic [7:0] shin, next_shin, wr_byte;
  logic [3:0] addr, next_addr;
  logic multi_access_bit, next_multi_access_bit, wr_en, rd_start, timeout;
  logic [31:0] shout, next_shout;
  logic [5:0] rdcnt, next_rdcnt;
  logic [12:0] tocnt, next_tocnt, to_lim;
  logic stat_en, fresh, overrange_flag, invalid_pend;
  logic [23:0] data;
  logic [4:0] tag;
  logic [7:0] status;

  always_comb begin
    stat_en = cfg_regs[0][`ADCSP_STAT_BIT];
    status = {fresh, overrange_flag, supply_low, tag};
    to_lim = cfg_regs[0][`ADCSP_TOSEL_BIT] ? `ADCSP_TO_SHORT_CYC : `ADCSP_TO_LONG_CYC;
    timeout = tocnt == to_lim - 13'h0001;
    wr_byte = {shin[6:0], din_c};
    next_state = state;
    next_bits = bits;
    next_shin = shin;
    next_addr = addr;
    next_multi_access_bit = multi_access_bit;
    next_shout = shout;
    next_rdcnt = rdcnt;
    next_tocnt = (sclk_rise || sclk_fall) ? 13'h0000 : tocnt + 13'h0001;
    wr_en = 1'b0;
    reset_cmd = 1'b0;
    rd_start = 1'b0;
    if (cs_c || timeout) begin
      // Deselect or idle clock aborts any transfer
      next_state = adcsp_pkg::st_cmd;
      next_bits = 3'h0;
      next_tocnt = 13'h0000;
      next_shout = '0;
    end else begin
      if (sclk_rise && state != adcsp_pkg::st_read) begin
        next_bits = bits + 3'h1;
        next_shin = wr_byte;
      end
      unique case (state)
        adcsp_pkg::st_cmd: begin
          if (sclk_rise && bits == 3'h7) begin
            // Decode code, multi bit and address of the command byte
            next_addr = wr_byte[3:0];
            next_multi_access_bit = wr_byte[4];
            if (wr_byte[7:5] == `ADCSP_CMD_WRITE) begin
              next_state = adcsp_pkg::st_write;
            end else if (wr_byte[7:5] == `ADCSP_CMD_RESET) begin
              reset_cmd = 1'b1;
            end else if (wr_byte[7:5] == `ADCSP_CMD_RDDATA) begin
              next_state = adcsp_pkg::st_read;
              next_rdcnt = 6'h00;
            end
          end
        end
        adcsp_pkg::st_write: begin
          if (sclk_rise && bits == 3'h7) begin
            // One whole byte per register, then step or finish
            wr_en = addr != `ADCSP_ID_ADDR && addr < `ADCSP_LAST_ADDR;
            if (multi_access_bit && addr < `ADCSP_LAST_ADDR) begin
              next_addr = addr + 4'h1;
            end else begin
              next_state = adcsp_pkg::st_cmd;
            end
          end
        end
        adcsp_pkg::st_read: begin
          if (sclk_fall) begin
            if (rdcnt == 6'h00) begin
              // Snapshot status and result, MSB first
              rd_start = 1'b1;
              next_shout = stat_en ? {status, data} : {data, 8'h00};
              next_rdcnt = stat_en ? `ADCSP_LEN_STAT : `ADCSP_LEN_NOSTAT;
            end else if (rdcnt == 6'h01) begin
              next_state = adcsp_pkg::st_cmd;
              next_shout = '0;
            end else begin
              next_shout = {shout[30:0], 1'b0};
              next_rdcnt = rdcnt - 6'h01;
            end
          end
        end
      endcase
    end
  end

  // Command state registers; data out is meaningless during command byte
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= adcsp_pkg::st_cmd;
      bits <= 3'h0;
      shin <= 8'h00;
      addr <= 4'h0;
      multi_access_bit <= 1'b0;
      shout <= '0;
      rdcnt <= 6'h00;
      tocnt <= 13'h0000;
    end else if (ce) begin
      state <= next_state;
      bits <= next_bits;
      shin <= next_shin;
      addr <= next_addr;
      multi_access_bit <= next_multi_access_bit;
      shout <= next_shout;
      rdcnt <= next_rdcnt;
      tocnt <= next_tocnt;
    end
  end

  // Data out is released whenever chip select is high
  always_comb begin
    dout = shout[31];
    dout_oe = !cs_c;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [`ADCSP_NREG-1:0][7:0] next_cfg;
  always_comb begin
    next_cfg = cfg_regs;
    if (reset_cmd) begin
      next_cfg = CFG_DEF;
    end else if (wr_en) begin
      next_cfg[addr] = wr_byte;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_regs <= CFG_DEF;
    end else if (ce) begin
      cfg_regs <= next_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result register fed from the FIFO; stalls while a readout runs
  adcsp_pkg::adcsp_result_t fifo_out;
  logic fifo_valid, drain, upd;
  logic [23:0] next_data;
  logic [4:0] next_tag;
  logic next_fresh, next_overrange_flag, next_inv, next_pend;

  adcsp_fifo #(.WIDTH(30), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data(conv_result),
    .out_valid(fifo_valid),
    .out_ready(drain),
    .out_data(fifo_out)
  );

  always_comb begin
    drain = state != adcsp_pkg::st_read;
    upd = fifo_valid && drain;
    next_data = data;
    next_tag = tag;
    next_overrange_flag = overrange_flag;
    next_inv = result_invalid;
    next_pend = invalid_pend;
    next_fresh = fresh;
    if (rd_start) begin
      next_fresh = 1'b0;
    end
    if (upd) begin
      // Newest result replaces an unread one; set wins over clear
      next_fresh = 1'b1;
      next_data = fifo_out.data;
      if (fifo_out.overrange_flag) begin
        next_data = fifo_out.data[23] ? `ADCSP_NEG_FS : `ADCSP_POS_FS;
      end
      next_tag = fifo_out.tag;
      next_overrange_flag = fifo_out.overrange_flag;
      next_inv = invalid_pend;
      next_pend = 1'b0;
    end
    if (reset_cmd) begin
      next_pend = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      data <= 24'h000000;
      tag <= 5'h00;
      overrange_flag <= 1'b0;
      fresh <= 1'b0;
      result_invalid <= 1'b0;
      invalid_pend <= 1'b0;
    end else if (ce) begin
      data <= next_data;
      tag <= next_tag;
      overrange_flag <= next_overrange_flag;
      fresh <= next_fresh;
      result_invalid <= next_inv;
      invalid_pend <= next_pend;
    end
  end
  assign result_ready_n = !fresh;

  ////////////////////////////////////////////////////////////////////////
  // Assertions and covers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || !ce);

  a_cs_abort: assert property (cs_c |=> state == adcsp_pkg::st_cmd && bits == 3'h0)
    else $error("chip select high did not abort");
  a_dout_release: assert property (cs_c |=> shout == 32'h00000000)
    else $error("data out driven while deselected");
  a_write_store: assert property (wr_en && !reset_cmd |=> cfg_regs[$past(addr)] == $past(wr_byte))
    else $error("write byte not stored");
  a_id_keep: assert property (cfg_regs[`ADCSP_ID_ADDR] == ID_VALUE)
    else $error("identification register changed");
  a_reset_dflt: assert property (reset_cmd |=> cfg_regs == CFG_DEF)
    else $error("reset command left non-default value");
  a_multi_step: assert property (wr_en && multi_access_bit |=> addr == $past(addr) + 4'h1)
    else $error("multi write did not step address");
  a_fresh_set: assert property (upd |=> fresh && !result_ready_n)
    else $error("update did not set fresh flag");
  a_fresh_read: assert property (rd_start |=> !fresh && shout[31:24] == (stat_en ? $past(status) : data[23:16]))
    else $error("read did not clear flag or start with status");
  a_sat_pos: assert property (upd && fifo_out.overrange_flag && !fifo_out.data[23] |=> data == `ADCSP_POS_FS)
    else $error("overrange not saturated");
  a_read_len: assert property (rd_start |=> rdcnt == (stat_en ? `ADCSP_LEN_STAT : `ADCSP_LEN_NOSTAT))
    else $error("readout length wrong");
  a_tag_legal: assert property (tag <= `ADCSP_TAG_LAST_EXT || tag == `ADCSP_TAG_OFFSET
    || (tag >= `ADCSP_TAG_SUPPLY && tag <= `ADCSP_TAG_REF))
    else $error("illegal channel tag");
  c_multi_write: cover property (wr_en && multi_access_bit && addr == 4'h8);
  c_reset_cmd: cover property (reset_cmd);
  c_read_stat: cover property (rd_start && stat_en && fresh);
  c_timeout: cover property (timeout && !cs_c);
endmodule

// file: bench/adcsp_host.sv
/*
  Behavioural serial host for the converter command port.
  Assumes mclk at 20 MHz; pins move on its rising edge, link clock period 400 ns.
*/
`timescale 1ns/1ps
module adcsp_host (
  input wire logic mclk,
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout_line
);
  // Pins start deselected with the link clock parked low
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    din = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Released data line toggles so a stale level never reads as data
  always @(posedge mclk) begin
    if (cs_n) begin
      din <= ~din;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Moves chip select, then lets the pin sync chain settle
  task automatic select(input logic lvl);
    @(posedge mclk);
    cs_n <= lvl;
    repeat (6) @(posedge mclk);
  endtask

  // Shifts n bits MSB first; data set at falling, dout taken at end of high
  task automatic shift(input int n, input logic [39:0] tx, output logic [39:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      din <= tx[i];
      repeat (4) @(posedge mclk);
      sclk <= 1'h1;
      repeat (4) @(posedge mclk);
      rx[i] = dout_line; // Command-byte bits kept but never judged
      sclk <= 1'h0;
    end
  endtask
endmodule

// file: bench/adc_serial_write_reset_and_data_format_bench.sv
/*
  Self-checking bench of the converter serial command port and result FIFO.
  Assumes rtl/adcsp_pkg.sv, rtl/adcsp_top.sv and bench/adcsp_host.sv compiled first.
*/
`timescale 1ns/1ps
`include "adcsp_consts.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module adc_serial_write_reset_and_data_format_bench;
  localparam logic [7:0] ID_VAL = 8'hC3; // Arbitrary identification value
  logic mclk, srst, ce, conv_valid, supply_low;
  logic cs_n, sclk, din, dout, dout_oe, conv_ready, result_ready_n, result_invalid, reset_cmd;
  wire logic dout_line = dout_oe ? dout : 1'hz;
  logic [`ADCSP_NREG-1:0][7:0] cfg_regs;
  logic [9:0][7:0] exp_cfg;
  adcsp_pkg::adcsp_result_t conv_result, res;
  logic [39:0] rx;
  logic [4:0] tags [9] = '{5'h00, 5'h07, 5'h08, 5'h17, 5'h18, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  int err_total = 0, total_checks = 0, cyc = 0, pulses = 0;

  // 20 MHz master clock
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  adcsp_top #(.ID_VALUE(ID_VAL), .FIFO_DEPTH(8)) dut (.mclk(mclk), .srst(srst), .ce(ce), .cs_n(cs_n),
    .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_result(conv_result), .supply_low(supply_low),
    .result_ready_n(result_ready_n), .result_invalid(result_invalid), .cfg_regs(cfg_regs),
    .reset_cmd(reset_cmd));
  adcsp_host host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout_line(dout_line));

  ////////////////////////////////////////////////////////////////////////
  // Counts reset command pulses and cuts a hung run short
  always @(posedge mclk) begin
    cyc++;
    if (reset_cmd === 1'h1) begin
      pulses++;
    end
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Register defaults, identification value last
  function automatic logic [9:0][7:0] dflt();
    return {ID_VAL, `ADCSP_RST_PORT_DATA, `ADCSP_RST_PORT_DIR, `ADCSP_RST_MON_SCAN, `ADCSP_RST_SINGLE_SCAN_HI,
      `ADCSP_RST_SINGLE_SCAN_LO, `ADCSP_RST_PAIR_SCAN, `ADCSP_RST_FIXED_SEL, `ADCSP_RST_CONV_CTL1,
      `ADCSP_RST_CONV_CTL0};
  endfunction

  // Expected readout: status byte then the saturated result
  function automatic logic [31:0] exp_rd(input adcsp_pkg::adcsp_result_t r, input logic fr, input logic sup);
    logic [23:0] d;
    d = r.overrange_flag ? (r.data[23] ? `ADCSP_NEG_FS : `ADCSP_POS_FS) : r.data;
    return {fr, r.overrange_flag, sup, r.tag, d};
  endfunction

  // Random conversion result carrying a given tag
  function automatic adcsp_pkg::adcsp_result_t rnd(input logic [4:0] t);
    adcsp_pkg::adcsp_result_t r;
    r.data = 24'($urandom);
    r.overrange_flag = ($urandom % 4) == 0;
    r.tag = t;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Compares every configuration register with the model
  task automatic chk_cfg();
    for (int i = 0; i < 10; i++) begin
      `CHK(cfg_regs[i], exp_cfg[i])
    end
  endtask

  // One single-register write frame
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.select(1'h0);
    host.shift(16, {24'h0, 3'h3, 1'h0, a, d}, rx);
    host.select(1'h1);
    if (a < 4'h9) exp_cfg[a] = d;
  endtask

  // One readout frame of nb bits after the command byte
  task automatic rd(input int nb, input logic [31:0] e);
    host.select(1'h0);
    `CHK(dout_oe, 1'h1)
    host.shift(8 + nb, 40'h30 << nb, rx);
    host.select(1'h1);
    `CHK(dout_oe, 1'h0)
    `CHK(nb == 32 ? rx[31:0] : {8'h00, rx[23:0]}, nb == 32 ? e : {8'h00, e[23:0]})
  endtask

  // Offers one result and waits, at most 40 cycles, until conv_ready is seen high after an edge
  task automatic push(input adcsp_pkg::adcsp_result_t r);
    int n;
    n = 0;
    conv_valid <= 1'h1;
    conv_result <= r;
    do begin
      @(posedge mclk);
      n++;
    end while (conv_ready !== 1'h1 && n < 40);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] v;
    int s;
    srst = 1'h1;
    ce = 1'h1;
    conv_valid = 1'h0;
    conv_result = '0;
    supply_low = 1'h0;
    void'($urandom(32'h91A4F8BE));
    repeat (16) @(posedge mclk);
    srst <= 1'h0;
    exp_cfg = dflt();
    repeat (4) @(posedge mclk);
    chk_cfg();
    `CHK(result_ready_n, 1'h1)
    // Clock enable low freezes the port: a whole write frame is lost
    v = 8'($urandom) | 8'h01;
    ce <= 1'h0;
    wr(4'h2, v);
    ce <= 1'h1;
    exp_cfg = dflt();
    repeat (4) @(posedge mclk);
    chk_cfg();
    // Single writes: identification register, an unmapped place, then random places
    for (int i = 0; i < 6; i++) begin
      wr(i == 0 ? 4'h9 : i == 1 ? 4'hB : 4'($urandom % 9), 8'($urandom));
      chk_cfg();
    end
    // Multi write runs through 09h, then the next byte is a fresh command
    s = $urandom % 9;
    host.select(1'h0);
    host.shift(8, {32'h0, 3'h3, 1'h1, 4'(s)}, rx);
    for (int a = s; a < 10; a++) begin
      v = 8'($urandom);
      host.shift(8, {32'h0, v}, rx);
      if (a < 9) exp_cfg[a] = v;
    end
    v = 8'($urandom);
    host.shift(16, {24'h0, 3'h3, 1'h0, 4'(s), v}, rx);
    exp_cfg[s] = v;
    host.select(1'h1);
    chk_cfg();
    // Chip select high in mid-byte drops the partial byte
    host.select(1'h0);
    host.shift(12, {28'h0, 3'h3, 1'h0, 4'h2, 4'hF}, rx);
    host.select(1'h1);
    wr(4'h2, 8'($urandom));
    chk_cfg();
    // Short timeout, stray bits, idle link, then the reset command
    wr(4'h0, 8'h4A);
    host.select(1'h0);
    host.shift(5, 40'h0, rx);
    repeat (300) @(posedge mclk);
    pulses = 0;
    host.shift(8, {32'h0, 3'h6, 5'($urandom)}, rx);
    host.select(1'h1);
    exp_cfg = dflt();
    chk_cfg();
    `CHK(pulses, 1)
    // First result after the reset command is flagged, the next is not
    for (int i = 0; i < 2; i++) begin
      push(rnd(5'h00));
      conv_valid <= 1'h0;
      repeat (4) @(posedge mclk);
      `CHK(result_invalid, 1'(i == 0))
    end
    // Every listed tag, four- and three-byte formats in turn, read twice
    for (int i = 0; i < 9; i++) begin
      wr(4'h0, i[0] ? 8'h08 : 8'h0A);
      supply_low <= 1'($urandom);
      res = rnd(tags[i]);
      push(res);
      conv_valid <= 1'h0;
      repeat (4) @(posedge mclk);
      `CHK(result_ready_n, 1'h0)
      rd(i[0] ? 24 : 32, exp_rd(res, 1'h1, supply_low));
      `CHK(result_ready_n, 1'h1)
      rd(i[0] ? 24 : 32, exp_rd(res, 1'h0, supply_low));
    end
    // A long read stalls the drain: the FIFO fills and refuses, the newest result wins
    wr(4'h0, 8'h0A);
    fork
      begin
        host.select(1'h0);
        host.shift(40, 40'h30_0000_0000, rx);
        host.select(1'h1);
      end
      begin
        repeat (100) @(posedge mclk);
        for (int k = 0; k < 8; k++) begin
          res = rnd(5'h1D);
          push(res);
        end
        conv_valid <= 1'h0;
        @(posedge mclk);
        `CHK(conv_ready, 1'h0)
      end
    join
    repeat (20) @(posedge mclk);
    rd(32, exp_rd(res, 1'h1, supply_low));
    final_report();
  end
endmodule
